// ---- src/qcdr_common_regs.sv ----
`timescale 1ns/100ps
module qcdr_common_regs #(
  parameter logic [7:0] REV_CODE  = qcdr_pkg::REV_CODE_DEFAULT,
  parameter logic [7:0] PART_CODE = qcdr_pkg::PART_CODE_DEFAULT
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  input  wire logic [3:0] signal_loss_flag,
  input  wire logic [3:0] lol,
  output logic            sdo,
  output logic            sdo_oe_n,
  output logic [1:0]      int_edge_rate,
  output logic [1:0]      ext_edge_rate,
  output logic [2:0]      int_drive_sel,
  output logic [2:0]      ext_drive_sel,
  output logic            channel_reset
);

  // ==========================================================================
  // decode helpers
  // ==========================================================================
  // one-hot {small, medium, high}; unused code falls back to the weakest
  function automatic logic [2:0] drive_decode(input logic [1:0] code);
    logic [2:0] sel;
    sel = 3'h4;
    unique case (code)
      qcdr_pkg::RATE_HIGH:   sel = 3'h1;
      qcdr_pkg::RATE_MEDIUM: sel = 3'h2;
      default:               sel = 3'h4;
    endcase
    return sel;
  endfunction

  // ==========================================================================
  // pin synchronisation
  // ==========================================================================
  logic [10:0] sync_bus;
  logic        sclk_s;
  logic        cs_n_s;
  logic        sdi_s;
  logic [3:0]  los_s;
  logic [3:0]  lol_s;
  logic [7:0]  live_flags;

  qcdr_sync #(
    .WIDTH   (qcdr_pkg::SYNC_WIDTH),
    .RST_VAL (qcdr_pkg::SYNC_RESET)
  ) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .din  ({1'b0, cs_n, sdi, signal_loss_flag, lol} | {sclk, 10'h000}),
    .dout (sync_bus)
  );

  assign sclk_s = sync_bus[10];
  assign cs_n_s = sync_bus[9];
  assign sdi_s  = sync_bus[8];
  assign los_s  = sync_bus[7:4];
  assign lol_s  = sync_bus[3:0];

  // interleave per channel: lock flag low, signal flag high
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_live
      assign live_flags[2*k]   = lol_s[k];
      assign live_flags[2*k+1] = los_s[k];
    end
  endgenerate

  // ==========================================================================
  // serial frame engine
  // ==========================================================================
  qcdr_pkg::qcdr_state_t state;
  qcdr_pkg::qcdr_state_t next_state;
  logic       sclk_d;
  logic       next_sclk_d;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] next_shift_in;
  logic [7:0] shift_out;
  logic [7:0] next_shift_out;
  logic [7:0] addr;
  logic [7:0] next_addr;
  logic       is_read;
  logic       next_is_read;
  logic       wr_stb;
  logic       next_wr_stb;
  logic [7:0] wr_data;
  logic [7:0] next_wr_data;
  logic       next_sdo;
  logic       next_sdo_oe_n;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [7:0] new_addr;
  logic [7:0] rd_data;

  // register state, declared early for the read mux
  logic [1:0] int_rate;
  logic [1:0] ext_rate;
  logic       grst;
  logic [7:0] sticky;
  logic [7:0] live_q;

  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign new_addr  = {shift_in[6:0], sdi_s};

  // read mux: only 20h, 22h, 23h, 26h and 27h answer, anything else (21h included) reads zero
  always_comb begin
    rd_data = qcdr_pkg::READ_ZERO;
    unique case (new_addr)
      qcdr_pkg::ADDR_EDGE_RATE: begin
        rd_data[qcdr_pkg::INT_RATE_POS+:2] = int_rate;
        rd_data[qcdr_pkg::EXT_RATE_POS+:2] = ext_rate;
      end
      qcdr_pkg::ADDR_REVISION: rd_data = REV_CODE;
      qcdr_pkg::ADDR_PART_ID:  rd_data = PART_CODE;
      qcdr_pkg::ADDR_LIVE:     rd_data = live_q;
      qcdr_pkg::ADDR_STICKY:   rd_data = sticky;
      default:                 rd_data = qcdr_pkg::READ_ZERO;
    endcase
  end

  // frame sequencing; cs_n high aborts any frame at once
  always_comb begin
    next_state     = state;
    next_sclk_d    = sclk_s;
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_addr      = addr;
    next_is_read   = is_read;
    next_wr_stb    = 1'b0;
    next_wr_data   = wr_data;
    next_sdo       = sdo;
    next_sdo_oe_n  = sdo_oe_n;
    if (cs_n_s) begin
      next_state    = qcdr_pkg::QCDR_IDLE;
      next_bit_cnt  = 4'h0;
      next_sdo      = 1'b0;
      next_sdo_oe_n = 1'b1;
    end else begin
      unique case (state)
        qcdr_pkg::QCDR_IDLE: begin
          next_state   = qcdr_pkg::QCDR_CMD;
          next_bit_cnt = 4'h0;
        end
        qcdr_pkg::QCDR_CMD: begin
          if (sclk_rise) begin
            next_shift_in = new_addr;
            next_bit_cnt  = bit_cnt + 4'h1;
            if (bit_cnt == 4'h0) begin
              next_is_read = sdi_s;
            end
            if (bit_cnt == qcdr_pkg::CMD_BITS - 4'h1) begin
              next_addr    = new_addr;
              next_bit_cnt = 4'h0;
              next_state   = qcdr_pkg::QCDR_DATA;
              if (is_read) begin
                // msb out now; host samples it on the next rising edge
                next_sdo       = rd_data[7];
                next_shift_out = {rd_data[6:0], 1'b0};
                next_sdo_oe_n  = 1'b0;
              end
            end
          end
        end
        qcdr_pkg::QCDR_DATA: begin
          if (sclk_rise) begin
            next_shift_in = new_addr;
            next_bit_cnt  = bit_cnt + 4'h1;
            if (bit_cnt == qcdr_pkg::DATA_BITS - 4'h1) begin
              next_state = qcdr_pkg::QCDR_DONE;
              if (!is_read) begin
                next_wr_stb  = 1'b1;
                next_wr_data = new_addr;
              end
            end
          end else if (sclk_fall && is_read && bit_cnt != 4'h0) begin
            // no shift before the host took the first data bit
            next_sdo       = shift_out[7];
            next_shift_out = {shift_out[6:0], 1'b0};
          end
        end
        qcdr_pkg::QCDR_DONE: begin
          next_state = qcdr_pkg::QCDR_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state     <= qcdr_pkg::QCDR_IDLE;
      sclk_d    <= 1'b0;
      bit_cnt   <= 4'h0;
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      addr      <= 8'h00;
      is_read   <= 1'b0;
      wr_stb    <= 1'b0;
      wr_data   <= 8'h00;
      sdo       <= 1'b0;
      sdo_oe_n  <= 1'b1;
    end else begin
      state     <= next_state;
      sclk_d    <= next_sclk_d;
      bit_cnt   <= next_bit_cnt;
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      addr      <= next_addr;
      is_read   <= next_is_read;
      wr_stb    <= next_wr_stb;
      wr_data   <= next_wr_data;
      sdo       <= next_sdo;
      sdo_oe_n  <= next_sdo_oe_n;
    end
  end

  // ==========================================================================
  // common register group
  // ==========================================================================
  logic [1:0] next_int_rate;
  logic [1:0] next_ext_rate;
  logic       next_grst;
  logic [7:0] next_sticky;
  logic [7:0] next_live_q;
  logic [2:0] next_int_drive_sel;
  logic [2:0] next_ext_drive_sel;

  // writes only hit 20h and 21h; read-only and unmapped writes vanish
  always_comb begin
    next_int_rate = int_rate;
    next_ext_rate = ext_rate;
    next_grst     = grst;
    next_live_q   = live_flags;
    if (wr_stb) begin
      unique case (addr)
        qcdr_pkg::ADDR_EDGE_RATE: begin
          next_int_rate = wr_data[qcdr_pkg::INT_RATE_POS+:2];
          next_ext_rate = wr_data[qcdr_pkg::EXT_RATE_POS+:2];
        end
        qcdr_pkg::ADDR_SOFT_RESET: begin
          if (wr_data == qcdr_pkg::GLOBAL_RESET_KEY) begin
            next_grst = ~grst;
          end
        end
        default: next_grst = grst;
      endcase
    end
    // global reset clears the persistent copy, a live event still wins
    next_sticky = (grst ? qcdr_pkg::STATUS_RESET : sticky) | live_flags;
    next_int_drive_sel = drive_decode(next_int_rate);
    next_ext_drive_sel = drive_decode(next_ext_rate);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      int_rate      <= qcdr_pkg::RATE_RESET;
      ext_rate      <= qcdr_pkg::RATE_RESET;
      grst          <= 1'b0;
      sticky        <= qcdr_pkg::STATUS_RESET;
      live_q        <= qcdr_pkg::STATUS_RESET;
      int_edge_rate <= qcdr_pkg::RATE_RESET;
      ext_edge_rate <= qcdr_pkg::RATE_RESET;
      int_drive_sel <= 3'h4;
      ext_drive_sel <= 3'h4;
      channel_reset <= 1'b0;
    end else begin
      int_rate      <= next_int_rate;
      ext_rate      <= next_ext_rate;
      grst          <= next_grst;
      sticky        <= next_sticky;
      live_q        <= next_live_q;
      int_edge_rate <= next_int_rate;
      ext_edge_rate <= next_ext_rate;
      int_drive_sel <= next_int_drive_sel;
      ext_drive_sel <= next_ext_drive_sel;
      channel_reset <= next_grst;
    end
  end

endmodule

// ---- src/qcdr_pkg.sv ----
package qcdr_pkg;

  // ==========================================================================
  // register map of the common group
  // ==========================================================================
  localparam logic [7:0] ADDR_EDGE_RATE  = 8'h20;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h21;
  localparam logic [7:0] ADDR_REVISION   = 8'h22;
  localparam logic [7:0] ADDR_PART_ID    = 8'h23;
  localparam logic [7:0] ADDR_LIVE       = 8'h26;
  localparam logic [7:0] ADDR_STICKY     = 8'h27;

  // ==========================================================================
  // field layout and codes
  // ==========================================================================
  localparam int         INT_RATE_POS    = 4;
  localparam int         EXT_RATE_POS    = 0;
  localparam logic [1:0] RATE_HIGH       = 2'h0;
  localparam logic [1:0] RATE_MEDIUM     = 2'h1;
  localparam logic [1:0] RATE_SMALL      = 2'h2;
  localparam logic [1:0] RATE_RESET      = RATE_SMALL;
  localparam logic [7:0] GLOBAL_RESET_KEY = 8'hAA;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // arbitrary neutral identity values
  localparam logic [7:0] REV_CODE_DEFAULT  = 8'h01;
  localparam logic [7:0] PART_CODE_DEFAULT = 8'h5A;

  // ==========================================================================
  // serial frame: read flag, 8 address bits, 8 data bits, msb first
  // ==========================================================================
  localparam logic [3:0] CMD_BITS  = 4'h9;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam int         SYNC_WIDTH = 11;
  // cs_n idles high, everything else low
  localparam logic [10:0] SYNC_RESET = 11'h200;

  typedef enum logic [1:0] {
    QCDR_IDLE = 2'b00,
    QCDR_CMD  = 2'b01,
    QCDR_DATA = 2'b10,
    QCDR_DONE = 2'b11
  } qcdr_state_t;

endpackage

// ---- src/qcdr_sync.sv ----
`timescale 1ns/100ps
module qcdr_sync #(
  parameter int                    WIDTH   = 1,
  parameter logic [WIDTH-1:0]      RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  // ==========================================================================
  // two-flop synchroniser
  // ==========================================================================
  // first stage is read only by the second stage
  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stage1 <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end

endmodule

// ---- verification/qcdr_host_model.sv ----
`timescale 1ns/100ps
module qcdr_host_model (
  input  wire logic mclk,
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  output logic      sclk = 1'b0,
  output logic      cs_n = 1'b1,
  output logic      sdi  = 1'b0
);
  // ==========================================================================
  // one frame: rw flag, address, data, msb first
  // ==========================================================================
  // six mclk per sclk phase, so sdo has settled well before each rise
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [16:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge mclk);
    cs_n <= 1'b0;
    for (int i = 16; i >= 0; i--) begin
      repeat (3) @(posedge mclk);
      sdi <= f[i];
      repeat (3) @(posedge mclk);
      sclk <= 1'b1;
      // an undriven sdo line shows the inverse, never a stale bit
      if (rd && i < 8) q[i] = sdo_oe_n ? ~sdo : sdo;
      repeat (6) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// ---- verification/qcdr_regs_assertions.sv ----
`timescale 1ns/100ps
module qcdr_regs_chk (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       cs_n,
  input wire logic       sdo,
  input wire logic       sdo_oe_n,
  input wire logic [1:0] int_edge_rate,
  input wire logic [1:0] ext_edge_rate,
  input wire logic [2:0] int_drive_sel,
  input wire logic [2:0] ext_drive_sel,
  input wire logic       channel_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // select held high long enough for the synchroniser to see it
  // ==========================================================================
  sequence s_idle;
    cs_n [*6];
  endsequence
  // expected one-hot {small, medium, high}; the unused code counts as small
  function automatic logic [2:0] exp_sel(input logic [1:0] code);
    return (code == qcdr_pkg::RATE_HIGH) ? 3'h1 : (code == qcdr_pkg::RATE_MEDIUM) ? 3'h2 : 3'h4;
  endfunction
  a_int_decode: assert property (int_drive_sel == exp_sel(int_edge_rate))
    else $error("internal drive select wrong");
  a_ext_decode: assert property (ext_drive_sel == exp_sel(ext_edge_rate))
    else $error("external drive select wrong");
  a_rate_hold: assert property (s_idle |=> $stable({int_edge_rate, ext_edge_rate}))
    else $error("edge rate moved outside a frame");
  a_rst_hold: assert property (s_idle |=> $stable(channel_reset))
    else $error("channel reset moved outside a frame");
  a_rst_frame: assert property ($changed(channel_reset) |-> !$past(cs_n, 2))
    else $error("channel reset changed without a frame");
  a_sdo_quiet: assert property (sdo_oe_n |-> !sdo)
    else $error("sdo not low while undriven");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:5] sdo_oe_n)
    else $error("sdo enable not released");
  a_oe_cs: assert property (!sdo_oe_n |-> !$past(cs_n, 5))
    else $error("sdo driven without select");
endmodule
bind qcdr_common_regs qcdr_regs_chk u_chk (
  .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
  .int_edge_rate(int_edge_rate), .ext_edge_rate(ext_edge_rate),
  .int_drive_sel(int_drive_sel), .ext_drive_sel(ext_drive_sel), .channel_reset(channel_reset)
);

// ---- verification/quad_cdr_common_registers_tb.sv ----
`timescale 1ns/100ps
module quad_cdr_common_registers_tb;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] signal_loss_flag  = 4'h0;
  logic [3:0] lol  = 4'h0;
  logic       sclk, cs_n, sdi, sdo, sdo_oe_n, crst;
  logic [1:0] ier, eer;
  logic [2:0] ids, eds;
  logic [7:0] q, v;
  int         fails = 0;
  int         checks_done = 0;

  // ==========================================================================
  // clock, design and host
  // ==========================================================================
  initial forever #12.5 mclk = ~mclk;
  qcdr_common_regs DUT (.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .signal_loss_flag(signal_loss_flag), .lol(lol),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .int_edge_rate(ier), .ext_edge_rate(eer), .int_drive_sel(ids),
    .ext_drive_sel(eds), .channel_reset(crst));
  qcdr_host_model host (.mclk(mclk), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic print_verdict;
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.xfer(1'b1, a, 8'h00, q);
    chk(q, exp);
  endtask
  // reset long enough for every synchroniser stage to settle
  task automatic reset_check;
    nrst <= 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({2'h0, ier, 2'h0, eer}, 8'h22);
    chk({ids, eds, crst, sdo_oe_n}, 8'h91);
  endtask

  // watchdog against a hung frame; 20000 clock cycles is far above a clean run
  initial begin
    #500000;
    fails++;
    print_verdict();
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    reset_check();
    for (int c = 0; c < 3; c++) begin
      v = {2'h0, c[1:0], 2'h0, 2'(2 - c)};
      wr(8'h20, v);
      chk({2'h0, ier, 2'h0, eer}, v);
      chk({2'h0, ids, eds}, {2'h0, 3'(1 << c), 3'(4 >> c)});
      rd(8'h20, v);
    end
    wr(8'h22, 8'hFF);
    rd(8'h22, qcdr_pkg::REV_CODE_DEFAULT);
    rd(8'h23, qcdr_pkg::PART_CODE_DEFAULT);
    rd(8'h24, 8'h00);
    rd(8'h60, 8'h00);
    signal_loss_flag <= 4'hA;
    lol <= 4'h5;
    rd(8'h26, 8'h99);
    signal_loss_flag <= 4'h0;
    lol <= 4'h0;
    rd(8'h26, 8'h00);
    rd(8'h27, 8'h99);
    wr(8'h21, 8'h55);
    chk({7'h0, crst}, 8'h00);
    wr(8'h21, qcdr_pkg::GLOBAL_RESET_KEY);
    chk({7'h0, crst}, 8'h01);
    wr(8'h21, 8'h55);
    chk({7'h0, crst}, 8'h01);
    wr(8'h21, qcdr_pkg::GLOBAL_RESET_KEY);
    chk({7'h0, crst}, 8'h00);
    rd(8'h27, 8'h00);
    signal_loss_flag <= 4'h4;
    repeat (10) @(posedge mclk);
    signal_loss_flag <= 4'h0;
    rd(8'h27, 8'h20);
    reset_check();
    rd(8'h27, 8'h00);
    print_verdict();
  end
endmodule
